// >>> src/rtcai_defs.svh
// Register offsets, field positions (the select field's among them) and reset values of the
// alarm and periodic interrupt block.
// Assumes it is included once per compilation unit by its bare name.
`ifndef RTCAI_DEFS_SVH
`define RTCAI_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTCAI_ADDR_ENABLE_CONFIG 4'hE
`define RTCAI_ADDR_FLAGS_MONITOR 4'hF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTCAI_BIT_WEEKLY_EN 7
`define RTCAI_BIT_DAILY_EN 6
`define RTCAI_BIT_DAILY_FLAG 0
`define RTCAI_BIT_WEEKLY_FLAG 1
`define RTCAI_BIT_PERIODIC_FLAG 2
`define RTCAI_SEL_MSB 2
`define RTCAI_SEL_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTCAI_RST_ENABLE_CONFIG 8'h00
`define RTCAI_RST_FLAGS 3'h0

`endif

// >>> src/rtcai_pkg.sv
// Types shared by the alarm and periodic interrupt block.
// Assumes nothing of its surroundings.
`default_nettype none
package rtcai_pkg;

  // Codes of the three-bit periodic select field.
  typedef enum logic [2:0] {
    RTCAI_PER_OFF = 3'h0,
    RTCAI_PER_LOW = 3'h1,
    RTCAI_PER_2HZ = 3'h2,
    RTCAI_PER_1HZ = 3'h3,
    RTCAI_PER_SEC = 3'h4,
    RTCAI_PER_MIN = 3'h5,
    RTCAI_PER_HOUR = 3'h6,
    RTCAI_PER_MONTH = 3'h7
  } rtcai_per_sel_t;

  typedef logic [7:0] rtcai_byte_t;

endpackage : rtcai_pkg
`default_nettype wire

// >>> src/rtcai_irq.sv
// Alarm and periodic interrupt logic of the real-time clock: two alarm
// comparators, the periodic source, the two control registers and the
// shared open-drain interrupt pin.
// Assumes the serial port, time counters and tick pulses all run on
// core_clk, so none of their signals needs a synchroniser.
`timescale 1ns/10ps
`default_nettype none
`include "rtcai_defs.svh"

module rtcai_irq (
  input wire logic core_clk,
  input wire logic rst_n,
  // Register access from the serial port.
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire rtcai_pkg::rtcai_byte_t reg_wdata,
  output rtcai_pkg::rtcai_byte_t reg_rdata,
  // Running time counters.
  input wire logic [2:0] cur_dow,
  input wire logic [5:0] cur_hour,
  input wire logic [6:0] cur_min,
  // Alarm settings.
  input wire logic [6:0] weekly_alarm_dow_mask,
  input wire logic [5:0] weekly_alarm_hour,
  input wire logic [6:0] weekly_alarm_min,
  input wire logic [5:0] daily_alarm_hour,
  input wire logic [6:0] daily_alarm_min,
  // Timebase pulses, one cycle each.
  input wire logic quarter_tick,
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic hour_tick,
  input wire logic month_tick,
  // Open-drain interrupt pin.
  output logic irq_out_n_o,
  output logic irq_out_n_oe_n
);
  import rtcai_pkg::*;

  // ----------------------------------------------------------------------
  // Control register and decode
  // ----------------------------------------------------------------------
  rtcai_byte_t enable_config_q;
  logic weekly_alarm_enable;
  logic daily_alarm_enable;
  rtcai_per_sel_t per_sel;
  logic wr_cfg;
  logic wr_flags;

  assign wr_cfg = reg_wr && (reg_addr == `RTCAI_ADDR_ENABLE_CONFIG);
  assign wr_flags = reg_wr && (reg_addr == `RTCAI_ADDR_FLAGS_MONITOR);
  assign weekly_alarm_enable = enable_config_q[`RTCAI_BIT_WEEKLY_EN];
  assign daily_alarm_enable = enable_config_q[`RTCAI_BIT_DAILY_EN];
  assign per_sel = rtcai_per_sel_t'(enable_config_q[`RTCAI_SEL_MSB:`RTCAI_SEL_LSB]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_config_q <= `RTCAI_RST_ENABLE_CONFIG;
    end else if (wr_cfg) begin
      enable_config_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Alarm comparators
  // ----------------------------------------------------------------------
  logic weekly_match;
  logic daily_match;
  logic weekly_match_q;
  logic daily_match_q;
  logic weekly_hit;
  logic daily_hit;

  assign weekly_match = weekly_alarm_dow_mask[cur_dow] &&
                        (cur_hour == weekly_alarm_hour) &&
                        (cur_min == weekly_alarm_min);
  assign daily_match = (cur_hour == daily_alarm_hour) &&
                       (cur_min == daily_alarm_min);

  // Only the start of a match counts, so an alarm armed while the time
  // already equals its setting stays quiet until the next occurrence.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      weekly_match_q <= 1'b0;
      daily_match_q <= 1'b0;
    end else begin
      weekly_match_q <= weekly_match;
      daily_match_q <= daily_match;
    end
  end

  assign weekly_hit = weekly_alarm_enable && weekly_match && !weekly_match_q;
  assign daily_hit = daily_alarm_enable && daily_match && !daily_match_q;

  // ----------------------------------------------------------------------
  // Periodic source
  // ----------------------------------------------------------------------
  logic [1:0] phase_q;
  logic per_level_mode;
  logic per_event;
  logic pulse_low;

  // Quarter-second phase restarts on every second increment, so the
  // pulse edges line up with the second counter.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else if (sec_tick) begin
      phase_q <= 2'h0;
    end else if (quarter_tick) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_comb begin
    case (per_sel)
      RTCAI_PER_LOW: pulse_low = 1'b1;
      RTCAI_PER_2HZ: pulse_low = !phase_q[0];
      RTCAI_PER_1HZ: pulse_low = !phase_q[1];
      default: pulse_low = 1'b0;
    endcase
  end

  assign per_level_mode = enable_config_q[`RTCAI_SEL_MSB];

  always_comb begin
    case (per_sel)
      RTCAI_PER_SEC: per_event = sec_tick;
      RTCAI_PER_MIN: per_event = min_tick;
      RTCAI_PER_HOUR: per_event = hour_tick;
      RTCAI_PER_MONTH: per_event = month_tick;
      default: per_event = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  logic [2:0] flags_q;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set[`RTCAI_BIT_DAILY_FLAG] = daily_hit;
  assign flag_set[`RTCAI_BIT_WEEKLY_FLAG] = weekly_hit;
  assign flag_set[`RTCAI_BIT_PERIODIC_FLAG] = per_level_mode && per_event;
  assign flag_clr = wr_flags ? ~reg_wdata[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data and interrupt pin
  // ----------------------------------------------------------------------
  // flag bit positions
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `RTCAI_ADDR_ENABLE_CONFIG) begin
      reg_rdata <= enable_config_q;
    end else if (reg_addr == `RTCAI_ADDR_FLAGS_MONITOR) begin
      reg_rdata <= {5'h00, flags_q};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  logic irq_low_d;
  logic irq_low_q;

  assign irq_low_d = flags_q[`RTCAI_BIT_DAILY_FLAG] |
                     flags_q[`RTCAI_BIT_WEEKLY_FLAG] |
                     (flags_q[`RTCAI_BIT_PERIODIC_FLAG] && per_level_mode) |
                     pulse_low;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_low_q <= 1'b0;
    end else begin
      irq_low_q <= irq_low_d;
    end
  end

  // The pin only ever sinks current; the pull-up makes the high level.
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe_n = !irq_low_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_weekly_set;
    @(posedge core_clk) disable iff (!rst_n)
      weekly_alarm_enable && weekly_match && !weekly_match_q |=>
        flags_q[`RTCAI_BIT_WEEKLY_FLAG] ##1 !irq_out_n_oe_n;
  endproperty
  a_weekly_set: assert property (p_weekly_set)
    else $error("weekly match did not set flag and pull pin");

  property p_daily_set;
    @(posedge core_clk) disable iff (!rst_n)
      daily_alarm_enable && daily_match && !daily_match_q |=>
        flags_q[`RTCAI_BIT_DAILY_FLAG] ##1 !irq_out_n_oe_n;
  endproperty
  a_daily_set: assert property (p_daily_set)
    else $error("daily match did not set flag and pull pin");

  property p_disabled_no_set;
    @(posedge core_clk) disable iff (!rst_n)
      !daily_alarm_enable && !flags_q[`RTCAI_BIT_DAILY_FLAG] |=>
        !flags_q[`RTCAI_BIT_DAILY_FLAG];
  endproperty
  a_disabled_no_set: assert property (p_disabled_no_set)
    else $error("disabled daily alarm raised its flag");

  property p_rearm_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(weekly_alarm_enable) && weekly_match && weekly_match_q &&
      !flags_q[`RTCAI_BIT_WEEKLY_FLAG] |=> !flags_q[`RTCAI_BIT_WEEKLY_FLAG];
  endproperty
  a_rearm_quiet: assert property (p_rearm_quiet)
    else $error("alarm fired on re-enable at current time");

  property p_clear_zero;
    @(posedge core_clk) disable iff (!rst_n)
      wr_flags && !reg_wdata[0] && !daily_hit |=>
        !flags_q[`RTCAI_BIT_DAILY_FLAG];
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("writing 0 did not clear daily flag");

  property p_write_one_keeps;
    @(posedge core_clk) disable iff (!rst_n)
      wr_flags && reg_wdata[1] |=> $stable(flags_q[`RTCAI_BIT_WEEKLY_FLAG]) ||
        flags_q[`RTCAI_BIT_WEEKLY_FLAG];
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("writing 1 changed weekly flag");

  property p_clear_keeps_enable;
    @(posedge core_clk) disable iff (!rst_n)
      wr_flags && !wr_cfg |=> $stable(enable_config_q);
  endproperty
  a_clear_keeps_enable: assert property (p_clear_keeps_enable)
    else $error("flag write disturbed enables");

  property p_read_flags;
    @(posedge core_clk) disable iff (!rst_n)
      reg_addr == `RTCAI_ADDR_FLAGS_MONITOR |=>
        reg_rdata == {5'h00, $past(flags_q)};
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("flag read returned wrong bits");

  property p_any_source;
    @(posedge core_clk) disable iff (!rst_n)
      (|flags_q[1:0]) || (per_sel == RTCAI_PER_LOW) |=> !irq_out_n_oe_n;
  endproperty
  a_any_source: assert property (p_any_source)
    else $error("active source did not pull pin low");

  property p_idle_released;
    @(posedge core_clk) disable iff (!rst_n)
      flags_q == 3'h0 && per_sel == RTCAI_PER_OFF |=> irq_out_n_oe_n;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("pin pulled with no source");

  property p_level_flag;
    @(posedge core_clk) disable iff (!rst_n)
      per_sel == RTCAI_PER_SEC && sec_tick |=>
        flags_q[`RTCAI_BIT_PERIODIC_FLAG] ##1 !irq_out_n_oe_n;
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("level mode second event lost");

  property p_pulse_1hz;
    @(posedge core_clk) disable iff (!rst_n)
      per_sel == RTCAI_PER_1HZ && sec_tick && $stable(per_sel) |=>
        ##1 !irq_out_n_oe_n;
  endproperty
  a_pulse_1hz: assert property (p_pulse_1hz)
    else $error("1 Hz pulse not low after second increment");

  c_weekly: cover property (@(posedge core_clk) disable iff (!rst_n)
    weekly_hit ##2 !irq_out_n_oe_n);
  c_both: cover property (@(posedge core_clk) disable iff (!rst_n)
    flags_q[1] && flags_q[0]);
  c_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
    flags_q[0] ##1 !flags_q[0]);
  c_pulse: cover property (@(posedge core_clk) disable iff (!rst_n)
    per_sel == RTCAI_PER_2HZ && quarter_tick);

endmodule : rtcai_irq
`default_nettype wire

// >>> sim/rtcai_host.sv
// Host model: serial register access and the pulled-up interrupt line.
// Assumes the device register port and open-drain pin run on core_clk.
`timescale 1ns/10ps
`default_nettype none
module rtcai_host (
  input wire logic core_clk,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  input wire rtcai_pkg::rtcai_byte_t rdata,
  output logic [3:0] addr,
  output logic wr,
  output rtcai_pkg::rtcai_byte_t wdata,
  output logic irq_line
);
  import rtcai_pkg::*;
  // The board pull-up raises the line while the pin is released.
  assign irq_line = pin_oe_n ? 1'b1 : pin_o;
  initial begin
    addr = 4'h0;
    wr = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr_reg(input logic [3:0] a, input rtcai_byte_t d);
    @(negedge core_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge core_clk);
    wr = 1'b0;
    wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output rtcai_byte_t d);
    @(negedge core_clk);
    addr = a;
    @(negedge core_clk);
    d = rdata;
  endtask : rd_reg
endmodule : rtcai_host
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench of the alarm and periodic interrupt block.
// Assumes the host model drives the register port and resolves the pin.
`timescale 1ns/10ps
`default_nettype none
`include "rtcai_defs.svh"
module tb;
  import rtcai_pkg::*;
  logic core_clk, rst_n, qt, st, mt, ht, mo;
  logic [2:0] dow, d, nd, sel;
  logic [5:0] hr, h, dy_h, wk_h;
  logic [6:0] mn, m, dy_m, wk_m, mask;
  logic [3:0] addr;
  logic wr, pin_o, pin_oe_n, irq_line;
  rtcai_byte_t wdata, rdata, v;
  int failures, compares;
  localparam logic [3:0] AE = `RTCAI_ADDR_ENABLE_CONFIG;
  localparam logic [3:0] AF = `RTCAI_ADDR_FLAGS_MONITOR;
  rtcai_irq i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .cur_dow(dow), .cur_hour(hr), .cur_min(mn),
    .weekly_alarm_dow_mask(mask), .weekly_alarm_hour(wk_h), .weekly_alarm_min(wk_m),
    .daily_alarm_hour(dy_h), .daily_alarm_min(dy_m), .quarter_tick(qt), .sec_tick(st),
    .min_tick(mt), .hour_tick(ht), .month_tick(mo), .irq_out_n_o(pin_o),
    .irq_out_n_oe_n(pin_oe_n));
  rtcai_host i_host (.core_clk(core_clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .rdata(rdata), .addr(addr), .wr(wr), .wdata(wdata), .irq_line(irq_line));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic rtcai_byte_t flags_exp(input logic w, input logic y, input logic p);
    return {5'h00, p, w, y};
  endfunction : flags_exp
  function automatic logic pulse_exp(input logic [2:0] s, input logic [1:0] q);
    return (s == RTCAI_PER_2HZ) ? q[0] : q[1];
  endfunction : pulse_exp
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic rd_chk(input logic [3:0] a, input rtcai_byte_t e);
    rtcai_byte_t r;
    i_host.rd_reg(a, r);
    check(r, e);
  endtask : rd_chk
  task automatic at(input logic [2:0] w, input logic [5:0] hh, input logic [6:0] mm);
    @(negedge core_clk);
    dow = w;
    hr = hh;
    mn = mm;
  endtask : at
  task automatic tick(input logic [4:0] t);
    @(negedge core_clk);
    {mo, ht, mt, st, qt} = t;
    @(negedge core_clk);
    {mo, ht, mt, st, qt} = 5'h00;
  endtask : tick
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    {mo, ht, mt, st, qt} = 5'h00;
    {dow, hr, mn, mask, wk_h, wk_m, dy_h, dy_m} = '0;
    void'($urandom(54));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    check(irq_line, 1'b1);
    rd_chk(AE, 8'h00);
    rd_chk(AF, 8'h00);
    rd_chk(4'h3, 8'h00);
    v = {2'h0, 3'($urandom_range(7)), 3'h0};
    i_host.wr_reg(AE, v);
    rd_chk(AE, v);
    // A write to an unmapped address must leave both registers alone.
    i_host.wr_reg(4'h3, 8'hFF);
    rd_chk(AE, v);
    rd_chk(AF, 8'h00);
    for (int k = 0; k < 2; k++) begin
      h = 6'($urandom_range(23));
      m = 7'($urandom_range(58));
      d = 3'($urandom_range(6));
      nd = (d == 3'h6) ? 3'h0 : d + 3'h1;
      i_host.wr_reg(AE, 8'h00);
      {dy_h, wk_h, dy_m, wk_m, mask} = {h, h, m, m, 7'(7'h01 << d)};
      at(d, h, m + 7'h01);
      i_host.wr_reg(AE, k ? 8'h80 : 8'h40);
      at(d, h, m);
      cyc(3);
      check(irq_line, 1'b0);
      rd_chk(AF, flags_exp(1'(k), 1'(!k), 1'b0));
      i_host.wr_reg(AF, 8'hFF);
      cyc(2);
      check(irq_line, 1'b0);
      i_host.wr_reg(AF, 8'h00);
      cyc(2);
      check(irq_line, 1'b1);
      rd_chk(AE, k ? 8'h80 : 8'h40);
      at(d, h, m + 7'h01);
      at(nd, h, m);
      cyc(3);
      check(irq_line, 8'(k));
      i_host.wr_reg(AF, 8'h00);
      at(d, h, m + 7'h01);
      at(d, h, m);
      cyc(3);
      check(irq_line, 1'b0);
      i_host.wr_reg(AF, 8'h00);
    end
    i_host.wr_reg(AE, 8'h00);
    i_host.wr_reg(AE, 8'hC0);
    cyc(4);
    check(irq_line, 1'b1);
    at(d, h, m + 7'h01);
    at(d, h, m);
    cyc(3);
    rd_chk(AF, flags_exp(1'b1, 1'b1, 1'b0));
    i_host.wr_reg(AF, 8'hFE);
    cyc(2);
    check(irq_line, 1'b0);
    rd_chk(AF, flags_exp(1'b1, 1'b0, 1'b0));
    i_host.wr_reg(AF, 8'h00);
    i_host.wr_reg(AE, 8'h01);
    cyc(2);
    check(irq_line, 1'b0);
    for (int s = 2; s < 8; s++) begin
      sel = 3'(s);
      i_host.wr_reg(AE, {5'h00, sel});
      if (s < 4) begin
        for (int q = 0; q < 4; q++) begin
          tick(q == 0 ? 5'h03 : 5'h01);
          cyc(2);
          check(irq_line, pulse_exp(sel, 2'(q)));
        end
        rd_chk(AF, 8'h00);
      end else begin
        tick(5'h02);
        cyc(2);
        check(irq_line, s != 4);
        i_host.wr_reg(AF, 8'h00);
        tick(5'(5'h1E >> (7 - s)));
        cyc(2);
        check(irq_line, 1'b0);
        rd_chk(AF, flags_exp(1'b0, 1'b0, 1'b1));
        i_host.wr_reg(AF, 8'hFB);
        cyc(2);
        check(irq_line, 1'b1);
      end
    end
    i_host.wr_reg(AE, 8'h00);
    cyc(2);
    check(irq_line, 1'b1);
    // A second reset in mid-run, with the pin held low and both alarms
    // armed on the current time, must release the pin and clear both registers.
    i_host.wr_reg(AE, 8'hC1);
    cyc(2);
    check(irq_line, 1'b0);
    rst_n = 1'b0;
    cyc(2);
    check(irq_line, 1'b1);
    rst_n = 1'b1;
    rd_chk(AE, 8'h00);
    rd_chk(AF, 8'h00);
    cyc(2);
    check(irq_line, 1'b1);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
